// file: design/sbch_cksum.sv
// Running two's-complement checksum of the bytes sent in one section
`timescale 1ns/1ps
module sbch_cksum (
  input wire logic clk,
  input wire logic reset,
  input wire logic clear,
  input wire logic addEn,
  input wire logic [7:0] dataIn,
  output logic [7:0] checksum
);
  // Keeping the negated sum leaves the byte to send ready with no adder behind the port
  always_ff @(posedge clk)
  begin
    if (reset || clear)
      checksum <= 8'h00;
    else if (addEn)
      checksum <= checksum - dataIn; // [RULE22]
  end
endmodule

// file: design/sbch_host.sv
// Host controller that runs RAM-transfer and chip-erase sessions on the serial boot link
`timescale 1ns/1ps
`include "sbch_regs.svh"
// Overview of operation
// RULE1 - Start address sent as four bytes, MSB first
// RULE2 - Byte count sent upper byte, then lower byte
// RULE3 - Whole payload must fit in usable RAM
// RULE4 - Checksum byte follows address and count bytes
// RULE5 - Header answer: receive error, checksum error, normal
// RULE6 - Send exactly the declared number of payload bytes
// RULE7 - Payload checksum byte follows the last payload byte
// RULE8 - Payload answer: receive error, checksum error, normal
// RULE9 - Target jumps to start address after normal answer
// RULE10 - UART session opens with 0x86
// RULE11 - Sync mode sends 0x30 twice at sixteenth rate
// RULE12 - UART echo missing within five seconds means failure
// RULE13 - Sync: idle gap, slow clock, expect 0x30 back
// RULE14 - Target enables receiver before loading its answer
// RULE15 - Command receive error answers X8 in UART
// RULE16 - Known command echoed, unknown answers X1
// RULE17 - Erase password compared in order when required
// RULE18 - Erase password answer 0x48, 0x41 or 0x40
// RULE19 - Erase enable 0x54 echoed, else 0x58 or X1
// RULE20 - Erase ends with 0x4F success or 0x4C failure
// RULE21 - Erased flash uses 0xFF bytes as password
// RULE22 - Checksum is negated 8-bit sum of bytes
// RULE23 - Password needed unless requirement byte is 0xFF
// RULE24 - Target restarts at command byte after errors
module sbch_host #(
  parameter int TIMEOUT_CYCLES = `SBCH_ECHO_TIMEOUT_CYC,
  parameter int IDLE_CYCLES = `SBCH_SYNC_IDLE_CYC,
  parameter int UART_BIT_CYCLES = `SBCH_UART_BIT_CYC,
  parameter int SYNC_HALF_CYCLES = `SBCH_SYNC_HALF_CYC,
  parameter int SYNC_GAP_CYCLES = `SBCH_SYNC_GAP_CYC,
  parameter logic [31:0] RAM_LAST = `SBCH_RAM_LAST
)(
  input wire logic clk,
  input wire logic reset,
  input wire logic startValid,
  output logic startReady,
  input wire sbch_pkg::sbch_op_e startOp,
  input wire logic serialChannelSyncOrAsync,
  input wire logic [31:0] ramAddress,
  input wire logic [15:0] byteCount,
  input wire logic [95:0] password,
  input wire logic payloadValid,
  input wire logic [7:0] payloadData,
  output logic payloadReady,
  output logic doneValid,
  output sbch_pkg::sbch_status_e doneStatus,
  output logic [7:0] lastAck,
  output logic bootSerialChannelTx,
  input wire logic bootSerialChannelRx,
  output logic syncShiftClockIn
);
  import sbch_pkg::*;
  sbch_state_e state, prevState;
  sbch_op_e opLatched;
  sbch_status_e rxRes, finStatus;
  logic syncLatched, pending, linkReqValid, linkReqReady, linkReqSend, linkSlow, hs;
  logic linkRespValid, linkRespError, timeout, finish, rangeOk, rxPoll, ckClear, ckAdd;
  logic [7:0] txByte, linkRespByte, cmdByte, checksum, expHdrCk;
  logic [31:0] addrLatched;
  logic [15:0] countLatched, remain, payCnt;
  logic [32:0] lastByteAddr;
  logic [95:0] pwShift;
  logic [47:0] hdrShift;
  logic [3:0] idx;
  logic [27:0] cnt;

  function automatic logic isAnswer(input sbch_state_e s);
    return s inside {S_MODE2, S_CMDACK, S_PWACK, S_HDRACK, S_DATAACK, S_ENACK, S_ERSRES};
  endfunction

  function automatic sbch_status_e ackCheck(input logic [7:0] ack, input logic [7:0] okVal);
    if (ack == okVal)
      return RES_OK;
    if (ack[3:0] == `SBCH_NIB_RXERR)
      return RES_ACK_RXERR;
    if (ack[3:0] == `SBCH_NIB_NAK)
      return RES_ACK_NAK;
    return RES_ACK_BAD;
  endfunction

  // Refuse a RAM session whose payload would leave usable RAM
  assign lastByteAddr = {1'b0, ramAddress} + {17'h00000, byteCount} - 33'h000000001;
  assign rangeOk = startOp == OP_ERASE || (ramAddress >= `SBCH_RAM_FIRST
    && (byteCount == 16'h0000 || lastByteAddr <= {1'b0, RAM_LAST})); // [RULE3]

  assign startReady = state == S_IDLE;
  assign cmdByte = opLatched == OP_RAM ? `SBCH_CMD_RAM : `SBCH_CMD_ERASE;
  assign linkSlow = syncLatched && (state == S_MODE1 || state == S_MODE2); // [RULE11]
  assign linkReqSend = !isAnswer(state) || (state == S_MODE2 && syncLatched);
  assign linkReqValid = !pending && state != S_IDLE && state != S_WAITIDLE
    && (state != S_DATA || payloadValid);
  assign hs = linkReqValid && linkReqReady;
  assign payloadReady = state == S_DATA && !pending && linkReqReady; // [RULE6]
  // One counter serves every answer wait; erase can be slow, so the limit is a parameter
  assign timeout = isAnswer(state) && pending && cnt == 28'(TIMEOUT_CYCLES - 1); // [RULE12]
  // In sync mode the erase result is polled until a final code shows up
  assign rxPoll = state == S_ERSRES && syncLatched && !linkRespError
    && linkRespByte != `SBCH_ERASE_DONE && linkRespByte != `SBCH_ERASE_FAIL;
  assign ckClear = linkRespValid && state inside {S_CMDACK, S_PWACK, S_HDRACK};
  assign ckAdd = hs && state inside {S_PW, S_HDR, S_DATA};

  always_comb
  begin
    case (state)
      S_MODE1, S_MODE2:
        txByte = syncLatched ? `SBCH_MODE_SYNC : `SBCH_MODE_UART; // [RULE10] [RULE11]
      S_CMD:
        txByte = cmdByte;
      S_PW:
        txByte = pwShift[95:88];
      S_HDR:
        txByte = hdrShift[47:40]; // [RULE1] [RULE2]
      S_PWCK, S_HDRCK, S_DATACK:
        txByte = checksum; // [RULE4] [RULE7]
      S_DATA:
        txByte = payloadData;
      S_ENABLE:
        txByte = `SBCH_ERASE_ENABLE; // [RULE19]
      default:
        txByte = `SBCH_DUMMY;
    endcase
  end

  always_comb
  begin
    if (linkRespError)
      rxRes = RES_LINK_ERR;
    else
      case (state)
        S_MODE2:
          rxRes = linkRespByte == (syncLatched ? `SBCH_MODE_SYNC : `SBCH_MODE_UART)
            ? RES_OK : RES_BAD_ECHO; // [RULE12] [RULE13]
        S_CMDACK, S_PWACK, S_HDRACK, S_DATAACK:
          rxRes = ackCheck(linkRespByte, cmdByte); // [RULE5] [RULE8]
        S_ENACK:
          rxRes = ackCheck(linkRespByte, `SBCH_ERASE_ENABLE); // [RULE19]
        S_ERSRES:
          rxRes = linkRespByte == `SBCH_ERASE_DONE ? RES_OK
            : linkRespByte == `SBCH_ERASE_FAIL ? RES_ERASE_FAIL : RES_ACK_BAD;
        default:
          rxRes = RES_OK;
      endcase
  end

  // Any error answer ends the session, as the target drops back to the command byte
  assign finish = (startValid && startReady && !rangeOk) || timeout
    || (linkRespValid && isAnswer(state) && !rxPoll
    && (rxRes != RES_OK || state == S_DATAACK || state == S_ERSRES)); // [RULE5] [RULE8]
  assign finStatus = startReady ? RES_RANGE : timeout ? RES_TIMEOUT : rxRes;

  always_ff @(posedge clk)
  begin
    if (reset || finish)
    begin
      state <= S_IDLE;
      pending <= 1'b0;
    end
    else
    begin
      if (hs)
        pending <= 1'b1;
      else if (linkRespValid)
        pending <= 1'b0;
      case (state)
        S_IDLE:
          if (startValid)
            state <= S_MODE1;
        S_MODE1:
          if (linkRespValid)
            state <= syncLatched ? S_WAITIDLE : S_MODE2; // [RULE10] [RULE11]
        S_WAITIDLE:
          if (cnt == 28'(IDLE_CYCLES - 1))
            state <= S_MODE2; // [RULE13]
        S_MODE2:
          if (linkRespValid)
            state <= S_CMD;
        S_CMD:
          if (linkRespValid)
            state <= S_CMDACK;
        S_CMDACK:
          if (linkRespValid)
            state <= S_PW;
        S_PW:
          if (linkRespValid && idx == `SBCH_PW_LAST)
            state <= S_PWCK;
        S_PWCK:
          if (linkRespValid)
            state <= S_PWACK;
        S_PWACK:
          if (linkRespValid)
            state <= opLatched == OP_RAM ? S_HDR : S_ENABLE;
        S_HDR:
          if (linkRespValid && idx == `SBCH_HDR_LAST)
            state <= S_HDRCK; // [RULE4]
        S_HDRCK:
          if (linkRespValid)
            state <= S_HDRACK;
        S_HDRACK:
          if (linkRespValid)
            state <= countLatched == 16'h0000 ? S_DATACK : S_DATA;
        S_DATA:
          if (linkRespValid && remain == 16'h0001)
            state <= S_DATACK; // [RULE6] [RULE7]
        S_DATACK:
          if (linkRespValid)
            state <= S_DATAACK;
        S_ENABLE:
          if (linkRespValid)
            state <= S_ENACK;
        S_ENACK:
          if (linkRespValid)
            state <= S_ERSRES;
        default:
          state <= state;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      opLatched <= OP_RAM;
      syncLatched <= 1'b0;
      addrLatched <= 32'h00000000;
      countLatched <= 16'h0000;
    end
    else if (startValid && startReady)
    begin
      opLatched <= startOp;
      syncLatched <= serialChannelSyncOrAsync;
      addrLatched <= ramAddress;
      countLatched <= byteCount;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pwShift <= 96'h0;
      hdrShift <= 48'h0;
      idx <= 4'h0;
      remain <= 16'h0000;
    end
    else if (startValid && startReady)
    begin
      pwShift <= password;
      hdrShift <= {ramAddress, byteCount}; // [RULE1] [RULE2]
      idx <= 4'h0;
    end
    else if (linkRespValid)
      case (state)
        S_PW:
        begin
          pwShift <= {pwShift[87:0], 8'h00};
          idx <= idx == `SBCH_PW_LAST ? 4'h0 : idx + 4'h1;
        end
        S_HDR:
        begin
          hdrShift <= {hdrShift[39:0], 8'h00};
          idx <= idx + 4'h1;
        end
        S_HDRACK:
          remain <= countLatched; // [RULE6]
        S_DATA:
          remain <= remain - 16'h0001;
        default:
          idx <= idx;
      endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      prevState <= S_IDLE;
      cnt <= 28'h0000000;
    end
    else
    begin
      prevState <= state;
      if (state != prevState)
        cnt <= 28'h0000000;
      else if (state == S_WAITIDLE || (isAnswer(state) && pending))
        cnt <= cnt + 28'h0000001;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      doneValid <= 1'b0;
      doneStatus <= RES_OK;
      lastAck <= 8'h00;
    end
    else
    begin
      doneValid <= finish;
      if (finish)
        doneStatus <= finStatus;
      if (linkRespValid)
        lastAck <= linkRespByte;
    end
  end

  sbch_cksum u_cksum (
    .clk(clk),
    .reset(reset),
    .clear(ckClear),
    .addEn(ckAdd),
    .dataIn(txByte),
    .checksum(checksum)
  );

  sbch_link #(
    .UART_BIT_CYCLES(UART_BIT_CYCLES),
    .SYNC_HALF_CYCLES(SYNC_HALF_CYCLES),
    .SYNC_GAP_CYCLES(SYNC_GAP_CYCLES)
  ) u_link (
    .clk(clk),
    .reset(reset),
    .syncMode(syncLatched),
    .slowRate(linkSlow),
    .abort(timeout),
    .reqValid(linkReqValid),
    .reqReady(linkReqReady),
    .reqSend(linkReqSend),
    .reqByte(txByte),
    .respValid(linkRespValid),
    .respByte(linkRespByte),
    .respError(linkRespError),
    .serialTx(bootSerialChannelTx),
    .serialRx(bootSerialChannelRx),
    .shiftClock(syncShiftClockIn)
  );

  // Helper count of payload bytes handed to the link
  always_ff @(posedge clk)
  begin
    if (reset || (startValid && startReady))
      payCnt <= 16'h0000;
    else if (payloadValid && payloadReady)
      payCnt <= payCnt + 16'h0001;
  end

  assign expHdrCk = 8'h00 - (addrLatched[31:24] + addrLatched[23:16] + addrLatched[15:8]
    + addrLatched[7:0] + countLatched[15:8] + countLatched[7:0]);

  a_addr_msb_first: assert property (@(posedge clk) disable iff (reset) // [RULE1]
    hs && state == S_HDR && idx == 4'h0 |-> txByte == addrLatched[31:24])
    else $error("address high byte not sent first");
  a_count_order: assert property (@(posedge clk) disable iff (reset) // [RULE2]
    hs && state == S_HDR && idx >= 4'h4 |->
    txByte == (idx == 4'h4 ? countLatched[15:8] : countLatched[7:0]))
    else $error("byte count halves out of order");
  a_range_guard: assert property (@(posedge clk) disable iff (reset) // [RULE3]
    state == S_MODE1 && $past(state) == S_IDLE && opLatched == OP_RAM
    |-> addrLatched >= `SBCH_RAM_FIRST)
    else $error("RAM session started below usable RAM");
  a_hdr_checksum: assert property (@(posedge clk) disable iff (reset) // [RULE4]
    hs && state == S_HDRCK |-> txByte == expHdrCk)
    else $error("header checksum byte wrong");
  a_payload_count: assert property (@(posedge clk) disable iff (reset) // [RULE6]
    hs && state == S_DATACK |-> payCnt == countLatched)
    else $error("payload byte count differs from declared count");
  a_data_then_ck: assert property (@(posedge clk) disable iff (reset) // [RULE7]
    linkRespValid && state == S_DATA && remain == 16'h0001 |=> state == S_DATACK)
    else $error("payload checksum does not follow last byte");
  a_uart_open: assert property (@(posedge clk) disable iff (reset) // [RULE10]
    hs && state == S_MODE1 && !syncLatched |-> txByte == `SBCH_MODE_UART && !linkSlow)
    else $error("UART session not opened with mode byte");
  a_sync_slow: assert property (@(posedge clk) disable iff (reset) // [RULE11]
    hs && syncLatched && (state == S_MODE1 || state == S_MODE2)
    |-> linkSlow && txByte == `SBCH_MODE_SYNC)
    else $error("sync opening bytes not slow 0x30");
  a_echo_timeout: assert property (@(posedge clk) disable iff (reset) // [RULE12]
    state == S_MODE2 && pending && cnt == 28'(TIMEOUT_CYCLES - 1)
    |=> state == S_IDLE && doneValid && doneStatus == RES_TIMEOUT)
    else $error("missing echo not reported as timeout");
  a_sync_idle: assert property (@(posedge clk) disable iff (reset) // [RULE13]
    state == S_MODE2 && $past(state) == S_WAITIDLE |-> $past(cnt) == 28'(IDLE_CYCLES - 1))
    else $error("sync idle gap length wrong");
  a_enable_byte: assert property (@(posedge clk) disable iff (reset) // [RULE19]
    hs && state == S_ENABLE |-> txByte == `SBCH_ERASE_ENABLE ##1 pending)
    else $error("erase enable byte wrong");
endmodule

// file: design/sbch_link.sv
// Byte engine of the boot link: UART frames or host-clocked synchronous shifts
`timescale 1ns/1ps
`include "sbch_regs.svh"
module sbch_link #(
  parameter int UART_BIT_CYCLES = `SBCH_UART_BIT_CYC,
  parameter int SYNC_HALF_CYCLES = `SBCH_SYNC_HALF_CYC,
  parameter int SYNC_GAP_CYCLES = `SBCH_SYNC_GAP_CYC
)(
  input wire logic clk,
  input wire logic reset,
  input wire logic syncMode,
  input wire logic slowRate,
  input wire logic abort,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqSend,
  input wire logic [7:0] reqByte,
  output logic respValid,
  output logic [7:0] respByte,
  output logic respError,
  output logic serialTx,
  input wire logic serialRx,
  output logic shiftClock
);
  import sbch_pkg::*;
  sbch_link_e st;
  logic rxMeta, rxLine, sending, clkLevel, txLevel;
  logic [15:0] timer, halfLoad, bitLoad;
  logic [3:0] bitCnt;
  logic [9:0] shiftOut;
  logic [7:0] shiftIn;

  assign halfLoad = slowRate ? 16'(SYNC_HALF_CYCLES * `SBCH_SLOW_FACTOR - 1)
                             : 16'(SYNC_HALF_CYCLES - 1);
  assign bitLoad = 16'(UART_BIT_CYCLES - 1);
  assign reqReady = st == LK_IDLE;
  assign serialTx = txLevel;
  assign shiftClock = clkLevel;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rxMeta <= 1'b1;
      rxLine <= 1'b1;
    end
    else
    begin
      rxMeta <= serialRx;
      rxLine <= rxMeta;
    end
  end

  // Sync mode: data changes with the falling clock, the far end samples on the rising one
  always_ff @(posedge clk)
  begin
    if (reset || abort)
    begin
      st <= LK_IDLE;
      timer <= 16'h0000;
      bitCnt <= 4'h0;
      shiftOut <= 10'h3FF;
      shiftIn <= 8'h00;
      sending <= 1'b0;
      txLevel <= 1'b1;
      clkLevel <= 1'b1;
      respValid <= 1'b0;
      respByte <= 8'h00;
      respError <= 1'b0;
    end
    else
    begin
      respValid <= 1'b0;
      case (st)
        LK_IDLE:
          if (reqValid)
          begin
            sending <= reqSend;
            bitCnt <= 4'h0;
            respError <= 1'b0;
            if (syncMode)
            begin
              shiftOut <= {2'b11, reqSend ? reqByte : `SBCH_DUMMY};
              timer <= reqSend ? halfLoad : 16'(SYNC_GAP_CYCLES - 1);
              clkLevel <= !reqSend;
              txLevel <= reqSend ? reqByte[0] : 1'b1;
              st <= reqSend ? LK_BITS : LK_GAP;
            end
            else
            begin
              shiftOut <= {1'b1, reqByte, 1'b0};
              txLevel <= !reqSend;
              timer <= bitLoad;
              st <= reqSend ? LK_BITS : LK_HUNT;
            end
          end
        LK_GAP:
          if (timer != 16'h0000)
            timer <= timer - 16'h0001;
          else
          begin
            clkLevel <= 1'b0;
            timer <= halfLoad;
            st <= LK_BITS;
          end
        LK_HUNT:
          if (!rxLine)
          begin
            timer <= 16'(UART_BIT_CYCLES / 2);
            st <= LK_BITS;
          end
        LK_BITS:
          if (timer != 16'h0000)
            timer <= timer - 16'h0001;
          else if (syncMode && !clkLevel)
          begin
            clkLevel <= 1'b1;
            shiftIn <= {rxLine, shiftIn[7:1]};
            timer <= halfLoad;
          end
          else if (syncMode ? bitCnt == 4'h7 : bitCnt == 4'h9)
          begin
            respValid <= 1'b1;
            respByte <= shiftIn;
            respError <= !syncMode && !sending && !rxLine;
            txLevel <= 1'b1;
            st <= LK_IDLE;
          end
          else if (!syncMode && !sending && bitCnt == 4'h0 && rxLine)
            st <= LK_HUNT;
          else
          begin
            bitCnt <= bitCnt + 4'h1;
            shiftOut <= {1'b1, shiftOut[9:1]};
            timer <= syncMode ? halfLoad : bitLoad;
            if (syncMode || sending)
              txLevel <= shiftOut[1];
            if (syncMode)
              clkLevel <= 1'b0;
            else if (!sending && bitCnt != 4'h0)
              shiftIn <= {rxLine, shiftIn[7:1]};
          end
        default:
          st <= LK_IDLE;
      endcase
    end
  end
endmodule

// file: pkg/sbch_pkg.sv
// Types of the serial boot host controller
package sbch_pkg;
  typedef enum logic [3:0] {RES_OK, RES_RANGE, RES_TIMEOUT, RES_BAD_ECHO, RES_LINK_ERR,
    RES_ACK_RXERR, RES_ACK_NAK, RES_ACK_BAD, RES_ERASE_FAIL} sbch_status_e;
  typedef enum logic {OP_RAM, OP_ERASE} sbch_op_e;
  typedef enum {S_IDLE, S_MODE1, S_WAITIDLE, S_MODE2, S_CMD, S_CMDACK, S_PW, S_PWCK,
    S_PWACK, S_HDR, S_HDRCK, S_HDRACK, S_DATA, S_DATACK, S_DATAACK, S_ENABLE, S_ENACK,
    S_ERSRES} sbch_state_e;
  typedef enum {LK_IDLE, LK_GAP, LK_HUNT, LK_BITS} sbch_link_e;
endpackage

// file: pkg/sbch_regs.svh
// Constants of the serial boot host controller
`ifndef SBCH_REGS_SVH
`define SBCH_REGS_SVH
`define SBCH_CLK_HZ 40000000
`define SBCH_ECHO_TIMEOUT_S 5
`define SBCH_ECHO_TIMEOUT_CYC (`SBCH_ECHO_TIMEOUT_S * `SBCH_CLK_HZ)
`define SBCH_SYNC_IDLE_MS 5
`define SBCH_SYNC_IDLE_CYC (`SBCH_SYNC_IDLE_MS * `SBCH_CLK_HZ / 1000)
`define SBCH_UART_BIT_CYC 347
`define SBCH_SYNC_HALF_CYC 20
`define SBCH_SYNC_GAP_CYC 400
`define SBCH_SLOW_FACTOR 16
`define SBCH_MODE_UART 8'h86
`define SBCH_MODE_SYNC 8'h30
`define SBCH_CMD_RAM 8'h10
`define SBCH_CMD_ERASE 8'h40
`define SBCH_ERASE_ENABLE 8'h54
`define SBCH_ERASE_DONE 8'h4F
`define SBCH_ERASE_FAIL 8'h4C
`define SBCH_NIB_RXERR 4'h8
`define SBCH_NIB_NAK 4'h1
`define SBCH_RAM_FIRST 32'h2000_0400
`define SBCH_RAM_LAST 32'h2000_0FFF
`define SBCH_PW_LAST 4'hB
`define SBCH_HDR_LAST 4'h5
`define SBCH_DUMMY 8'hFF
`endif

// file: tb/sbch_target.sv
// Behavioural boot target on the UART side of the link
`timescale 1ns/1ps
module sbch_target #(
  parameter int BIT = 8
)(
  input wire logic clk,
  input wire logic [2:0] fault,
  input wire logic hostTx,
  output logic devTx,
  output logic [31:0] gotAddr,
  output logic [15:0] gotCount,
  output logic [7:0] gotSum
);
  logic [7:0] b;
  logic [7:0] cmd;
  logic [7:0] s;
  // Samples mid-bit and adds each byte into the running sum
  task automatic getb();
    @(negedge hostTx);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT) @(posedge clk);
      b[i] = hostTx;
    end
    // Return at the end of the stop bit: the host only hunts once its own frame is done
    repeat (BIT + BIT / 2) @(posedge clk);
    s = s + b;
  endtask
  // Receiver is back on before the answer goes out
  task automatic putb(input logic [7:0] v);
    for (int i = 0; i < 10; i++)
    begin
      devTx <= (i == 0) ? 1'h0 : (i == 9) ? 1'h1 : v[i - 1];
      repeat (BIT) @(posedge clk);
    end
  endtask
  // Each session restarts at the mode byte, as after a fresh boot
  initial
  begin
    devTx = 1'h1;
    forever
    begin
      getb();
      if (fault == 3'h1)
        continue;
      putb(b);
      getb();
      // A garbled command takes its upper nibble from the previous command
      putb(fault == 3'h6 ? {cmd[7:4], 4'h8} : b);
      cmd = b;
      if (fault == 3'h6)
        continue;
      s = 8'h00;
      repeat (13) getb();
      // No password stored, so only the checksum of the 13 bytes is checked
      putb((s == 8'h00 && fault != 3'h5) ? cmd : cmd | 8'h01);
      if (s != 8'h00 || fault == 3'h5)
        continue;
      if (cmd == 8'h40)
      begin
        getb();
        putb(b == 8'h54 ? b : 8'h41);
        repeat (BIT * 4) @(posedge clk);
        putb(fault == 3'h4 ? 8'h4C : 8'h4F);
      end
      else
      begin
        s = 8'h00;
        for (int i = 0; i < 6; i++)
        begin
          getb();
          {gotAddr, gotCount} = {gotAddr[23:0], gotCount, b};
        end
        getb();
        putb(fault == 3'h3 ? 8'h18 : (fault == 3'h2 || s != 8'h00) ? 8'h11 : 8'h10);
        if (fault == 3'h2 || fault == 3'h3 || s != 8'h00)
          continue;
        s = 8'h00;
        repeat (gotCount) getb();
        gotSum = s;
        getb();
        // A normal answer hands control to the code at gotAddr; the model then reboots
        putb(s == 8'h00 ? 8'h10 : 8'h11);
      end
    end
  end
endmodule

// file: tb/tb.sv
// Self-checking bench of the serial boot host controller
`timescale 1ns/1ps
`include "sbch_regs.svh"
module tb;
  import sbch_pkg::*;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic startValid = 1'h0;
  sbch_op_e startOp = OP_RAM;
  logic syncSel = 1'h0;
  logic [31:0] ramAddress = 32'h0;
  logic [15:0] byteCount = 16'h0;
  logic [95:0] password = 96'h0;
  logic payloadValid = 1'h0;
  logic [7:0] payloadData = 8'h00;
  logic [2:0] fault = 3'h0;
  logic startReady, payloadReady, doneValid, hostTx, devTx, sck;
  sbch_status_e doneStatus;
  logic [7:0] lastAck, gotSum;
  logic [31:0] gotAddr;
  logic [15:0] gotCount;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  integer seed = 32'h1753;
  always #12.5 clk = ~clk;
  sbch_host #(.TIMEOUT_CYCLES(20000), .IDLE_CYCLES(50), .UART_BIT_CYCLES(8),
    .SYNC_HALF_CYCLES(4), .SYNC_GAP_CYCLES(20)) DUT (.clk, .reset, .startValid, .startReady,
    .startOp, .serialChannelSyncOrAsync(syncSel), .ramAddress, .byteCount, .password,
    .payloadValid, .payloadData, .payloadReady, .doneValid, .doneStatus, .lastAck,
    .bootSerialChannelTx(hostTx), .bootSerialChannelRx(devTx), .syncShiftClockIn(sck));
  sbch_target partner (.clk, .fault, .hostTx, .devTx, .gotAddr, .gotCount, .gotSum);
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Ceiling sits well above the longest expected run
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 80000)
    begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("FAIL at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  function automatic sbch_status_e expStatus(input sbch_op_e op, input logic sync,
    input logic [31:0] a, input logic [15:0] n, input logic [2:0] f);
    if (op == OP_RAM && (a < `SBCH_RAM_FIRST || (n != 0 && a + n - 1 > `SBCH_RAM_LAST)))
      return RES_RANGE;
    if (sync)
      return RES_BAD_ECHO;
    case (f)
      3'h1: return RES_TIMEOUT;
      3'h2, 3'h5: return RES_ACK_NAK;
      3'h3, 3'h6: return RES_ACK_RXERR;
      3'h4: return RES_ERASE_FAIL;
      default: return RES_OK;
    endcase
  endfunction
  function automatic logic [7:0] ackOf(input sbch_op_e op, input sbch_status_e e);
    case (e)
      RES_OK: return op == OP_RAM ? 8'h10 : 8'h4F;
      RES_ACK_NAK: return op == OP_RAM ? 8'h11 : 8'h41;
      RES_ACK_RXERR: return 8'h18;
      RES_ERASE_FAIL: return 8'h4C;
      default: return 8'hFF;
    endcase
  endfunction
  // Payload source stalls at random; data holds until taken
  task automatic run(input sbch_op_e op, input logic sync, input logic [31:0] a,
    input logic [15:0] n, input logic [2:0] f);
    sbch_status_e e;
    logic [7:0] s;
    logic [15:0] k;
    logic tk, dn, tg;
    check(startReady, 1'h1);
    e = expStatus(op, sync, a, n, f);
    s = 8'h00;
    k = 16'h0;
    dn = 1'h0;
    tg = 1'h0;
    startOp <= op;
    syncSel <= sync;
    ramAddress <= a;
    byteCount <= n;
    fault <= f;
    password <= {$random(seed), $random(seed), $random(seed)};
    startValid <= 1'h1;
    @(posedge clk);
    startValid <= 1'h0;
    while (!dn)
    begin
      @(negedge clk);
      tk = payloadReady === 1'h1 && payloadValid === 1'h1;
      dn = doneValid === 1'h1;
      tg = tg | (sck === 1'h0);
      @(posedge clk);
      if (tk)
      begin
        s = s + payloadData;
        k = k + 16'h1;
      end
      if (tk || !payloadValid)
      begin
        payloadValid <= 1'($random(seed));
        payloadData <= 8'($random(seed));
      end
    end
    check(doneStatus, e);
    check(tg, sync);
    if (e == RES_OK && op == OP_RAM)
    begin
      check({gotAddr, gotCount}, {a, n});
      check(gotSum, s);
      check(k, n);
    end
    if (e != RES_RANGE && e != RES_TIMEOUT)
      check(lastAck, ackOf(op, e));
    $display("test done, status %0d", e);
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    check(hostTx, 1'h1);
    run(OP_RAM, 1'h0, 32'h2000_0400, 16'h0, 3'h0);
    run(OP_RAM, 1'h0, 32'h2000_0FF0, 16'h10, 3'h0);
    for (int i = 0; i < 3; i++)
      run(OP_RAM, 1'h0, 32'h2000_0400 + (32'($random(seed)) & 32'h7FE),
        16'($random(seed) & 7) + 16'h1, 3'h0);
    run(OP_RAM, 1'h0, 32'h2000_03FF, 16'h4, 3'h0);
    run(OP_RAM, 1'h0, 32'h2000_0FF0, 16'h11, 3'h0);
    run(OP_RAM, 1'h0, 32'h2000_0800, 16'h3, 3'h2);
    run(OP_RAM, 1'h0, 32'h2000_0800, 16'h3, 3'h3);
    run(OP_RAM, 1'h0, 32'h2000_0800, 16'h3, 3'h6);
    run(OP_ERASE, 1'h0, 32'h0, 16'h0, 3'h0);
    run(OP_ERASE, 1'h0, 32'h0, 16'h0, 3'h4);
    run(OP_ERASE, 1'h0, 32'h0, 16'h0, 3'h5);
    run(OP_RAM, 1'h0, 32'h2000_0400, 16'h2, 3'h1);
    run(OP_RAM, 1'h1, 32'h2000_0400, 16'h2, 3'h1);
    wrap_up();
  end
endmodule
